// ==== src/wake_and_switch_status_bank.sv ====
// Wake source, input level and high-side switch status registers
// ==================================================
// Contract
// - Wake flags: LIN2,LIN1,CAN,timer,wake inputs three-one
// - Wake from fail-safe also sets source flag
// - Pin two/one wake flags, clear-on-read
// - Reserved bits always read zero
// - Bit 7 shows development mode strap
// - Bit 6 shows interrupt pull-up strap
// - Level register shows pin and wake levels
// - Pin levels update in normal/stop when configured
// - Cyclic wake inputs show last sample; pins not
// - Pin selected as GPIO always shows level
// - Overload flags latch per switch, clear-on-read
// - Open-load flags latch per switch, clear-on-read
// - Reset clears wake and switch status
// - Restart keeps flags, reserved bits zero
// - Overload may set at low supply; no masking
`default_nettype none
module wake_and_switch_status_bank
   import status_bank_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic rdStrobe,
   input wire logic [6:0] rdAddr,
   output logic [7:0] rdData,
   output logic rdValid,
   input wire logic linTwoWake,
   input wire logic linOneWake,
   input wire logic canWake,
   input wire logic timerWake,
   input wire logic [2:0] wakeInputEvt,
   input wire logic [1:0] pinWakeEvt,
   input wire logic [3:0] switchOverloadEvt,
   input wire logic [3:0] switchOpenLoadEvt,
   input wire sbc_mode_t opMode,
   input wire pin_cfg_t pinOneCfg,
   input wire pin_cfg_t pinTwoCfg,
   input wire logic pinOneGpioSel,
   input wire logic pinTwoGpioSel,
   input wire logic [2:0] wakeCyclic,
   input wire logic cyclicSample,
   input wire logic failOutputTestPin,
   input wire logic intPullupSense,
   input wire logic pinOneIn,
   input wire logic pinTwoIn,
   input wire logic [2:0] wakeInputPin
);
   // ==================================================
   // Helpers
   function automatic logic addrHit(input logic [6:0] a, input logic [6:0] ref_a);
      addrHit = (a == ref_a);
   endfunction

   function automatic logic pinLevelLive(input sbc_mode_t m, input pin_cfg_t c,
                                         input logic gpioSel);
      pinLevelLive = gpioSel ||
                     (((m == MODE_NORMAL) || (m == MODE_STOP)) && (c != PIN_OFF));
   endfunction

   // ==================================================
   // Pin synchronisers
   logic [6:0] syncLvl;
   logic syncDevStrap;
   logic syncPullup;
   logic [1:0] syncPin;
   logic [2:0] syncWake;

   level_sync #(.W(7)) u_pin_sync (
      .sys_clk(sys_clk),
      .asyncIn({failOutputTestPin, intPullupSense, pinTwoIn, pinOneIn, wakeInputPin}),
      .syncOut(syncLvl)
   );

   assign syncDevStrap = syncLvl[6];
   assign syncPullup = syncLvl[5];
   assign syncPin = syncLvl[4:3];
   assign syncWake = syncLvl[2:0];

   // ==================================================
   // Sticky flag registers
   logic [7:0] wakeASet;
   logic [7:0] wakeBSet;
   logic [7:0] wakeA_r;
   logic [7:0] wakeB_r;
   logic [7:0] overload_r;
   logic [7:0] openLoad_r;
   logic clrWakeA;
   logic clrWakeB;
   logic clrOverload;
   logic clrOpenLoad;

   // Events set flags in every mode, fail-safe and sleep alike
   always_comb begin
      wakeASet = 8'h00;
      wakeASet[LIN_TWO_WAKE_BIT] = linTwoWake;
      wakeASet[LIN_ONE_WAKE_BIT] = linOneWake;
      wakeASet[CAN_BUS_WAKE_BIT] = canWake;
      wakeASet[TIMER_WAKE_BIT] = timerWake;
      wakeASet[WAKE_INPUT_THREE_BIT] = wakeInputEvt[2];
      wakeASet[WAKE_INPUT_TWO_BIT] = wakeInputEvt[1];
      wakeASet[WAKE_INPUT_ONE_BIT] = wakeInputEvt[0];
      wakeBSet = 8'h00;
      wakeBSet[PIN_TWO_WAKE_BIT] = pinWakeEvt[1];
      wakeBSet[PIN_ONE_WAKE_BIT] = pinWakeEvt[0];
   end

   // Clear strobes come from the read itself; data is captured the same edge
   assign clrWakeA = rdStrobe && addrHit(rdAddr, WAKE_SOURCE_STATUS_A_ADDR);
   assign clrWakeB = rdStrobe && addrHit(rdAddr, WAKE_SOURCE_STATUS_B_ADDR);
   assign clrOverload = rdStrobe && addrHit(rdAddr, SWITCH_OVERLOAD_STATUS_ADDR);
   assign clrOpenLoad = rdStrobe && addrHit(rdAddr, SWITCH_OPEN_LOAD_STATUS_ADDR);

   // Masks keep reserved positions at zero through any reset or restart
   rc_flag_bank #(.VALID_MASK(WAKE_A_VALID_MASK)) u_wake_a (
      .sys_clk(sys_clk),
      .srst(srst),
      .setIn(wakeASet),
      .readClear(clrWakeA),
      .flags_r(wakeA_r)
   );

   rc_flag_bank #(.VALID_MASK(WAKE_B_VALID_MASK)) u_wake_b (
      .sys_clk(sys_clk),
      .srst(srst),
      .setIn(wakeBSet),
      .readClear(clrWakeB),
      .flags_r(wakeB_r)
   );

   // No supply qualification: low-supply overloads are latched as seen
   rc_flag_bank #(.VALID_MASK(SWITCH_VALID_MASK)) u_overload (
      .sys_clk(sys_clk),
      .srst(srst),
      .setIn({4'h0, switchOverloadEvt}),
      .readClear(clrOverload),
      .flags_r(overload_r)
   );

   // Open-load flags share the overload structure, one per switch
   rc_flag_bank #(.VALID_MASK(SWITCH_VALID_MASK)) u_open_load (
      .sys_clk(sys_clk),
      .srst(srst),
      .setIn({4'h0, switchOpenLoadEvt}),
      .readClear(clrOpenLoad),
      .flags_r(openLoad_r)
   );

   // ==================================================
   // Strap capture
   logic strapLoad_r;
   logic devStrap_r;
   logic cfgStrap_r;

   // Straps are caught once, on the first edge after reset release
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         strapLoad_r <= 1'b1;
      end else begin
         strapLoad_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         devStrap_r <= 1'b0;
         cfgStrap_r <= 1'b0;
      end else if (strapLoad_r) begin
         devStrap_r <= syncDevStrap;
         cfgStrap_r <= syncPullup;
      end
   end

   // ==================================================
   // Level tracking
   logic [1:0] pinLvl_r;
   logic [2:0] wakeLvl_r;

   // Pins cannot cyclic-sense, so cyclic settings never gate them
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pinLvl_r <= 2'b00;
      end else begin
         if (pinLevelLive(opMode, pinOneCfg, pinOneGpioSel)) begin
            pinLvl_r[0] <= syncPin[0];
         end
         if (pinLevelLive(opMode, pinTwoCfg, pinTwoGpioSel)) begin
            pinLvl_r[1] <= syncPin[1];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wakeLvl_r <= 3'b000;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (!wakeCyclic[i] || cyclicSample) begin
               wakeLvl_r[i] <= syncWake[i];
            end
         end
      end
   end

   logic [7:0] levelValue;

   always_comb begin
      levelValue = LEVEL_RESET_VALUE;
      levelValue[DEV_MODE_LEVEL_BIT] = devStrap_r;
      levelValue[PULLUP_STRAP_BIT] = cfgStrap_r;
      levelValue[PIN_TWO_LEVEL_BIT] = pinLvl_r[1];
      levelValue[PIN_ONE_LEVEL_BIT] = pinLvl_r[0];
      levelValue[WAKE_LEVEL_LSB +: 3] = wakeLvl_r;
   end

   // ==================================================
   // Read port
   logic [7:0] readMux;
   logic [6:0] lastAddr_r;

   always_comb begin
      case (rdAddr)
         WAKE_SOURCE_STATUS_A_ADDR: readMux = wakeA_r;
         WAKE_SOURCE_STATUS_B_ADDR: readMux = wakeB_r;
         INPUT_LEVEL_STATUS_ADDR: readMux = levelValue;
         SWITCH_OVERLOAD_STATUS_ADDR: readMux = overload_r;
         SWITCH_OPEN_LOAD_STATUS_ADDR: readMux = openLoad_r;
         default: readMux = UNMAPPED_READ_VALUE;
      endcase
   end

   // Value returned is the pre-clear content of the register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdData <= 8'h00;
         rdValid <= 1'b0;
         lastAddr_r <= 7'h00;
      end else begin
         rdValid <= rdStrobe;
         if (rdStrobe) begin
            rdData <= readMux;
            lastAddr_r <= rdAddr;
         end
      end
   end

   // ==================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_wake_flag_set: assert property (linTwoWake |=> wakeA_r[LIN_TWO_WAKE_BIT])
      else $error("LIN two wake event not latched");
   a_fail_safe_wake: assert property ((opMode == MODE_FAIL_SAFE) && canWake
      |=> wakeA_r[CAN_BUS_WAKE_BIT])
      else $error("CAN wake from fail-safe not latched");
   a_pin_wake_latch: assert property (pinWakeEvt[1] |=> wakeB_r[PIN_TWO_WAKE_BIT])
      else $error("Pin two wake flag lost");
   a_wake_b_mask: assert property (rdValid && (lastAddr_r == WAKE_SOURCE_STATUS_B_ADDR)
      |-> (rdData & ~WAKE_B_VALID_MASK) == 8'h00)
      else $error("Reserved pin wake bit read as one");
   a_level_reserved: assert property (rdValid && (lastAddr_r == INPUT_LEVEL_STATUS_ADDR)
      |-> rdData[3] == 1'b0)
      else $error("Reserved level bit read as one");
   a_reserved_zero: assert property (rdValid && (lastAddr_r == WAKE_SOURCE_STATUS_A_ADDR)
      |-> rdData[3] == 1'b0)
      else $error("Reserved wake bit read as one");
   a_dev_strap_held: assert property (!strapLoad_r |=> $stable(devStrap_r))
      else $error("Development strap changed after capture");
   a_dev_strap_load: assert property (strapLoad_r |=> devStrap_r == $past(syncDevStrap))
      else $error("Development strap not captured at release");
   a_cfg_strap_load: assert property (strapLoad_r |=> cfgStrap_r == $past(syncPullup))
      else $error("Pull-up strap not captured at release");
   a_pin_level_live: assert property ((opMode == MODE_NORMAL) && (pinOneCfg == PIN_WAKE_INPUT)
      |=> pinLvl_r[0] == $past(syncPin[0]))
      else $error("Pin one level not tracking in normal mode");
   a_pin_stop_live: assert property ((opMode == MODE_STOP) && (pinOneCfg == PIN_LOW_SIDE)
      |=> pinLvl_r[0] == $past(syncPin[0]))
      else $error("Pin one level not tracking in stop mode");
   a_cyclic_hold: assert property (wakeCyclic[0] && !cyclicSample |=> $stable(wakeLvl_r[0]))
      else $error("Cyclic wake level changed without a sample");
   a_gpio_level: assert property (pinTwoGpioSel |=> pinLvl_r[1] == $past(syncPin[1]))
      else $error("GPIO level not shown");
   a_overload_latch: assert property (switchOverloadEvt[2] |=> overload_r[2])
      else $error("Overload event not latched");
   a_open_load_latch: assert property (switchOpenLoadEvt[0] |=> openLoad_r[0])
      else $error("Open-load event not latched");
   a_reset_clears: assert property (@(posedge sys_clk) disable iff (1'b0)
      srst |=> (wakeA_r == 8'h00) && (overload_r == 8'h00))
      else $error("Status not cleared by reset");
   a_read_clears: assert property (clrOverload && !switchOverloadEvt[1]
      |=> !overload_r[1] && rdData[1] == $past(overload_r[1]))
      else $error("Clear-on-read returned or cleared wrongly");
   a_set_wins: assert property (clrOpenLoad && switchOpenLoadEvt[3]
      |=> openLoad_r[3] ##1 1'b1)
      else $error("Event lost during clearing read");

   c_wake_read: cover property (linOneWake ##[1:5] clrWakeA);
   c_set_on_clear: cover property (clrOverload && switchOverloadEvt[2]);
   c_stop_level: cover property ((opMode == MODE_STOP) && (pinOneCfg == PIN_LOW_SIDE));
   c_cyclic_sample: cover property (wakeCyclic[2] && cyclicSample);
   c_level_read: cover property (rdValid && (lastAddr_r == INPUT_LEVEL_STATUS_ADDR));
endmodule // wake_and_switch_status_bank
`default_nettype wire

// ==== src/status_bank_pkg.sv ====
// Package: register map, field positions, reset values and mode types of the status bank
`default_nettype none
package status_bank_pkg;
   // ==================================================
   // Register offsets (7-bit serial address)
   localparam logic [6:0] WAKE_SOURCE_STATUS_A_ADDR = 7'h46;
   localparam logic [6:0] WAKE_SOURCE_STATUS_B_ADDR = 7'h47;
   localparam logic [6:0] INPUT_LEVEL_STATUS_ADDR = 7'h48;
   localparam logic [6:0] SWITCH_OVERLOAD_STATUS_ADDR = 7'h54;
   localparam logic [6:0] SWITCH_OPEN_LOAD_STATUS_ADDR = 7'h55;

   // ==================================================
   // Field positions
   localparam int LIN_TWO_WAKE_BIT = 7;
   localparam int LIN_ONE_WAKE_BIT = 6;
   localparam int CAN_BUS_WAKE_BIT = 5;
   localparam int TIMER_WAKE_BIT = 4;
   localparam int WAKE_INPUT_THREE_BIT = 2;
   localparam int WAKE_INPUT_TWO_BIT = 1;
   localparam int WAKE_INPUT_ONE_BIT = 0;
   localparam int PIN_TWO_WAKE_BIT = 5;
   localparam int PIN_ONE_WAKE_BIT = 4;
   localparam int DEV_MODE_LEVEL_BIT = 7;
   localparam int PULLUP_STRAP_BIT = 6;
   localparam int PIN_TWO_LEVEL_BIT = 5;
   localparam int PIN_ONE_LEVEL_BIT = 4;
   localparam int WAKE_LEVEL_LSB = 0;

   // ==================================================
   // Reset values and read-as-zero masks
   localparam logic [7:0] STATUS_RESET_VALUE = 8'h00;
   localparam logic [7:0] LEVEL_RESET_VALUE = 8'h00;
   localparam logic [7:0] WAKE_A_VALID_MASK = 8'hf7;
   localparam logic [7:0] WAKE_B_VALID_MASK = 8'h30;
   localparam logic [7:0] SWITCH_VALID_MASK = 8'h0f;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

   // ==================================================
   // Modes and pin configurations
   typedef enum logic [2:0] {
      MODE_INIT,
      MODE_NORMAL,
      MODE_STOP,
      MODE_SLEEP,
      MODE_RESTART,
      MODE_FAIL_SAFE
   } sbc_mode_t;

   typedef enum logic [1:0] {
      PIN_OFF,
      PIN_WAKE_INPUT,
      PIN_LOW_SIDE,
      PIN_HIGH_SIDE
   } pin_cfg_t;
endpackage
`default_nettype wire

// ==== src/level_sync.sv ====
// Two-stage synchroniser for asynchronous pin levels
`default_nettype none
module level_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   logic [W-1:0] stageOne_r;

   // No reset: the chain keeps sampling during reset so straps are valid at release
   always_ff @(posedge sys_clk) begin
      stageOne_r <= asyncIn;
      syncOut <= stageOne_r;
   end
endmodule // level_sync
`default_nettype wire

// ==== src/rc_flag_bank.sv ====
// Sticky clear-on-read flag register with set priority over clear
`default_nettype none
module rc_flag_bank
   import status_bank_pkg::*;
#(
   parameter logic [7:0] VALID_MASK = 8'hff
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [7:0] setIn,
   input wire logic readClear,
   output logic [7:0] flags_r
);
   logic [7:0] flags_nxt;

   // Set wins so an event landing in the read cycle is seen on the next read
   always_comb begin
      flags_nxt = ((readClear ? 8'h00 : flags_r) | setIn) & VALID_MASK;
   end

   // Only power-on/soft reset (srst) or a clearing read clears; a restart leaves latched flags alone
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flags_r <= STATUS_RESET_VALUE;
      end else begin
         flags_r <= flags_nxt;
      end
   end
endmodule // rc_flag_bank
`default_nettype wire

// ==== test/status_reader.sv ====
// Serial master model that reads status registers through the read port
`default_nettype none
module status_reader (
   input wire logic sys_clk,
   input wire logic rdValid,
   input wire logic [7:0] rdData,
   output logic rdStrobe,
   output logic [6:0] rdAddr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==================================================
   // Read access
   initial begin
      rdStrobe = 1'b0;
      rdAddr = 7'h7f;
   end

   // Address goes to its inverse once taken, so a stale address is never read
   task automatic readReg(input logic [6:0] addr, output logic [7:0] data, output bit ok);
      int n;
      ok = 1'b0;
      data = 8'h00;
      @(negedge sys_clk);
      rdStrobe = 1'b1;
      rdAddr = addr;
      @(negedge sys_clk);
      rdStrobe = 1'b0;
      rdAddr = ~addr;
      for (n = 0; n < 4 && !ok; n++) begin
         if (rdValid === 1'b1) begin
            data = rdData;
            ok = 1'b1;
         end else begin
            @(negedge sys_clk);
         end
      end
   endtask
endmodule // status_reader
`default_nettype wire

// ==== test/tb_wake_and_switch_status_bank.sv ====
// Self-checking testbench for the wake and switch status bank
`default_nettype none
module tb_wake_and_switch_status_bank;
   timeunit 1ns;
   timeprecision 1ps;
   import status_bank_pkg::*;
   // ==================================================
   // Signals
   logic sys_clk, srst, rdStrobe, rdValid;
   logic [6:0] rdAddr;
   logic [7:0] rdData;
   logic linTwoWake, linOneWake, canWake, timerWake, cyclicSample;
   logic [2:0] wakeInputEvt, wakeCyclic, wakeInputPin;
   logic [1:0] pinWakeEvt;
   logic [3:0] switchOverloadEvt, switchOpenLoadEvt;
   sbc_mode_t opMode;
   pin_cfg_t pinOneCfg, pinTwoCfg;
   logic pinOneGpioSel, pinTwoGpioSel, failOutputTestPin, intPullupSense, pinOneIn, pinTwoIn;
   int errors = 0;
   int checks_done = 0;

   wake_and_switch_status_bank wake_and_switch_status_bank_inst (
      .sys_clk(sys_clk), .srst(srst), .rdStrobe(rdStrobe), .rdAddr(rdAddr),
      .rdData(rdData), .rdValid(rdValid), .linTwoWake(linTwoWake),
      .linOneWake(linOneWake), .canWake(canWake), .timerWake(timerWake),
      .wakeInputEvt(wakeInputEvt), .pinWakeEvt(pinWakeEvt),
      .switchOverloadEvt(switchOverloadEvt), .switchOpenLoadEvt(switchOpenLoadEvt),
      .opMode(opMode), .pinOneCfg(pinOneCfg), .pinTwoCfg(pinTwoCfg),
      .pinOneGpioSel(pinOneGpioSel), .pinTwoGpioSel(pinTwoGpioSel),
      .wakeCyclic(wakeCyclic), .cyclicSample(cyclicSample),
      .failOutputTestPin(failOutputTestPin), .intPullupSense(intPullupSense),
      .pinOneIn(pinOneIn), .pinTwoIn(pinTwoIn), .wakeInputPin(wakeInputPin));

   status_reader status_reader_inst (.sys_clk(sys_clk), .rdValid(rdValid),
      .rdData(rdData), .rdStrobe(rdStrobe), .rdAddr(rdAddr));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ==================================================
   // Shared tasks
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic checkRead(input logic [6:0] addr, input logic [7:0] exp);
      logic [7:0] got;
      bit ok;
      status_reader_inst.readReg(addr, got, ok);
      checks_done++;
      if (!ok) begin
         errors++;
         $display("wrong value rdValid expected 1 seen 0");
         complete_run();
      end else if (got !== exp) begin
         errors++;
         $display("wrong value reg %h expected %h seen %h", addr, exp, got);
      end
   endtask

   // Straps are only captured after release, so hold them through reset
   task automatic resetDut(input logic fot, input logic pull);
      @(negedge sys_clk);
      srst = 1'b1;
      failOutputTestPin = fot;
      intPullupSense = pull;
      repeat (4) @(negedge sys_clk);
      srst = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask

   // ==================================================
   // Scenarios
   task automatic scenStraps();
      resetDut(1'b1, 1'b0);
      checkRead(WAKE_SOURCE_STATUS_A_ADDR, 8'h00);
      checkRead(WAKE_SOURCE_STATUS_B_ADDR, 8'h00);
      checkRead(SWITCH_OVERLOAD_STATUS_ADDR, 8'h00);
      checkRead(SWITCH_OPEN_LOAD_STATUS_ADDR, 8'h00);
      checkRead(7'h49, 8'h00);
      checkRead(INPUT_LEVEL_STATUS_ADDR, 8'h80);
      resetDut(1'b0, 1'b1);
      checkRead(INPUT_LEVEL_STATUS_ADDR, 8'h40);
   endtask

   task automatic scenWake();
      int i;
      for (i = 0; i < 7; i++) begin
         @(negedge sys_clk);
         opMode = i[2] ? MODE_FAIL_SAFE : MODE_SLEEP;
         {linTwoWake, linOneWake, canWake, timerWake, wakeInputEvt} = 7'h01 << i;
         @(negedge sys_clk);
         {linTwoWake, linOneWake, canWake, timerWake, wakeInputEvt} = 7'h00;
         checkRead(WAKE_SOURCE_STATUS_A_ADDR, (i < 3) ? 8'h01 << i : 8'h01 << (i + 1));
      end
      checkRead(WAKE_SOURCE_STATUS_A_ADDR, 8'h00);
      for (i = 0; i < 2; i++) begin
         @(negedge sys_clk);
         pinWakeEvt = 2'b01 << i;
         @(negedge sys_clk);
         pinWakeEvt = 2'b00;
         checkRead(WAKE_SOURCE_STATUS_B_ADDR, 8'h10 << i);
      end
      checkRead(WAKE_SOURCE_STATUS_B_ADDR, 8'h00);
   endtask

   task automatic scenSwitch();
      int i;
      for (i = 0; i < 4; i++) begin
         @(negedge sys_clk);
         switchOverloadEvt = 4'h1 << i;
         switchOpenLoadEvt = 4'h8 >> i;
         @(negedge sys_clk);
         switchOverloadEvt = 4'h0;
         switchOpenLoadEvt = 4'h0;
         checkRead(SWITCH_OVERLOAD_STATUS_ADDR, 8'h01 << i);
         checkRead(SWITCH_OPEN_LOAD_STATUS_ADDR, 8'h08 >> i);
      end
      // Event lands on the very edge that takes the read
      fork
         checkRead(SWITCH_OVERLOAD_STATUS_ADDR, 8'h00);
         begin
            @(negedge sys_clk);
            switchOverloadEvt = 4'h4;
            @(negedge sys_clk);
            switchOverloadEvt = 4'h0;
         end
      join
      checkRead(SWITCH_OVERLOAD_STATUS_ADDR, 8'h04);
      fork
         checkRead(SWITCH_OPEN_LOAD_STATUS_ADDR, 8'h00);
         begin
            @(negedge sys_clk);
            switchOpenLoadEvt = 4'h8;
            @(negedge sys_clk);
            switchOpenLoadEvt = 4'h0;
         end
      join
      checkRead(SWITCH_OPEN_LOAD_STATUS_ADDR, 8'h08);
      checkRead(SWITCH_OVERLOAD_STATUS_ADDR, 8'h00);
   endtask

   task automatic scenLevels();
      @(negedge sys_clk);
      wakeInputPin = 3'b101;
      repeat (4) @(negedge sys_clk);
      checkRead(INPUT_LEVEL_STATUS_ADDR, 8'h45);
      wakeCyclic = 3'b111;
      wakeInputPin = 3'b010;
      repeat (4) @(negedge sys_clk);
      checkRead(INPUT_LEVEL_STATUS_ADDR, 8'h45);
      cyclicSample = 1'b1;
      @(negedge sys_clk);
      cyclicSample = 1'b0;
      checkRead(INPUT_LEVEL_STATUS_ADDR, 8'h42);
      opMode = MODE_NORMAL;
      pinOneCfg = PIN_WAKE_INPUT;
      pinOneIn = 1'b1;
      pinTwoIn = 1'b1;
      repeat (4) @(negedge sys_clk);
      checkRead(INPUT_LEVEL_STATUS_ADDR, 8'h52);
      opMode = MODE_SLEEP;
      pinOneIn = 1'b0;
      pinTwoCfg = PIN_HIGH_SIDE;
      pinTwoGpioSel = 1'b1;
      repeat (4) @(negedge sys_clk);
      checkRead(INPUT_LEVEL_STATUS_ADDR, 8'h72);
      opMode = MODE_STOP;
      pinOneCfg = PIN_LOW_SIDE;
      repeat (4) @(negedge sys_clk);
      checkRead(INPUT_LEVEL_STATUS_ADDR, 8'h62);
   endtask

   // ==================================================
   // Main sequence
   initial begin
      srst = 1'b1;
      {linTwoWake, linOneWake, canWake, timerWake, wakeInputEvt} = 7'h00;
      pinWakeEvt = 2'b00;
      switchOverloadEvt = 4'h0;
      switchOpenLoadEvt = 4'h0;
      opMode = MODE_INIT;
      pinOneCfg = PIN_OFF;
      pinTwoCfg = PIN_OFF;
      {pinOneGpioSel, pinTwoGpioSel, pinOneIn, pinTwoIn, cyclicSample} = 5'h00;
      {failOutputTestPin, intPullupSense} = 2'b00;
      wakeCyclic = 3'b000;
      wakeInputPin = 3'b000;
      scenStraps();
      scenWake();
      scenSwitch();
      scenLevels();
      complete_run();
   end
endmodule // tb_wake_and_switch_status_bank
`default_nettype wire
